// ---- rca_calendar_alarm.sv ----
/*
 * rca_calendar_alarm: time and calendar counters, access freeze with one
 * deferred tick, and alarm compare with a match flag.
 * Assumes tick_1hz, access_active and the register strobes come from logic on clk.
 */
//Behaviour
//[RULE_01] weekday is three bits, upper five read zero
//[RULE_02] weekday counts zero to six cyclically
//[RULE_03] month in bcd at 07h
//[RULE_04] year in bcd at 08h
//[RULE_05] counters frozen while host access runs
//[RULE_06] one tick held and applied after access
//[RULE_07] host finishes each access within one second
//[RULE_08] host reads all time registers in one burst
//[RULE_09] only enabled alarm fields are compared
//[RULE_10] minute alarm at 09h, disable bit reset one
//[RULE_11] hour alarm at 0Ah, bit six unused
//[RULE_12] hour alarm follows the hour format
//[RULE_13] day alarm at 0Bh, bit six unused
//[RULE_14] weekday alarm at 0Ch, bits six-three unused
//[RULE_15] format bit zero selects 24-hour mode
//[RULE_16] flag set when all enabled fields first match
//[RULE_17] persisting match does not set flag again
//[RULE_18] tick carries through to day, month, year
module rca_calendar_alarm
    import rca_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic tick_1hz,
    input wire logic access_active,
    input wire logic wr_en,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    input wire logic hour_mode_12,
    input wire logic alarm_flag_clear,
    output logic alarm_match_flag,
    output logic [7:0] sec_out,
    output logic [7:0] min_out,
    output logic [7:0] hr_out,
    output logic [7:0] date_out
);
    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hr;
        logic [7:0] date;
        logic [2:0] dow;
        logic [4:0] month;
        logic [7:0] year;
        logic [7:0] amin;
        logic [7:0] ahr;
        logic [7:0] adate;
        logic [7:0] adow;
        logic pending;
        logic match_prev;
        logic flag;
        logic [7:0] rdata;
    } rca_state_t;

    rca_state_t state_reg;
    rca_state_t state_next;

    // ----------------------------------------------------------------
    // counting chain
    // ----------------------------------------------------------------
    logic [7:0] sec_n, min_n, hr_n, date_n, month_n, year_n;
    logic sec_w, min_w, hr_w, date_w, month_w, year_w;
    logic [7:0] hr_last, hr_first, date_last;
    logic [7:0] hr_adv;
    logic leap;

    assign leap = (state_reg.year[4] ? (state_reg.year[3:0] == 4'h2 || state_reg.year[3:0] == 4'h6)
                                     : (state_reg.year[3:0] == 4'h0 || state_reg.year[3:0] == 4'h4
                                        || state_reg.year[3:0] == 4'h8));

    always_comb
    begin
        unique case (state_reg.month)
            5'h02: date_last = leap ? 8'h29 : 8'h28;
            5'h04, 5'h06, 5'h09, 5'h11: date_last = 8'h30;
            default: date_last = 8'h31;
        endcase
        if (hour_mode_12) // see [RULE_15]
        begin
            hr_last = 8'h12;
            hr_first = 8'h01;
        end
        else
        begin
            hr_last = 8'h23;
            hr_first = 8'h00;
        end
    end

    rca_bcd_digit u_sec (.cur(state_reg.sec), .last(8'h59), .first(8'h00), .nxt(sec_n),
                         .wrap(sec_w));
    rca_bcd_digit u_min (.cur(state_reg.min), .last(8'h59), .first(8'h00), .nxt(min_n),
                         .wrap(min_w));
    rca_bcd_digit u_hr (.cur({3'h0, state_reg.hr[4:0]} & (hour_mode_12 ? 8'h1F : 8'h3F)
                              | (hour_mode_12 ? 8'h00 : {2'h0, state_reg.hr[5], 5'h00})),
                        .last(hr_last), .first(hr_first), .nxt(hr_n), .wrap(hr_w));
    rca_bcd_digit u_date (.cur(state_reg.date), .last(date_last), .first(8'h01), .nxt(date_n),
                          .wrap(date_w));
    rca_bcd_digit u_month (.cur({3'h0, state_reg.month}), .last(8'h12), .first(8'h01),
                           .nxt(month_n), .wrap(month_w));
    rca_bcd_digit u_year (.cur(state_reg.year), .last(8'h99), .first(8'h00), .nxt(year_n),
                          .wrap(year_w));

    // 12-hour mode: 11->12 flips afternoon and ends the day only when leaving 11 pm; 12->01 does neither
    logic day_carry;
    always_comb
    begin
        if (hour_mode_12)
        begin
            hr_adv = {2'h0, state_reg.hr[RCA_AFTERNOON_BIT] ^ (state_reg.hr[4:0] == 5'h11),
                      hr_n[4:0]};
            day_carry = (state_reg.hr[5:0] == 6'h31);
        end
        else
        begin
            hr_adv = hr_n;
            day_carry = hr_w;
        end
    end

    // ----------------------------------------------------------------
    // alarm compare
    // ----------------------------------------------------------------
    logic match_now;
    logic hr_hit;
    // bit 5 is pm in 12-hour mode and a tens bit in 24-hour mode, so one compare covers both
    assign hr_hit = (state_reg.ahr[5:0] == state_reg.hr[5:0]); // see [RULE_12]
    assign match_now = !(state_reg.amin[7] & state_reg.ahr[7] & state_reg.adate[7]
                         & state_reg.adow[7])
        && (state_reg.amin[7] || state_reg.amin[6:0] == state_reg.min[6:0]) // see [RULE_09]
        && (state_reg.ahr[7] || hr_hit)
        && (state_reg.adate[7] || state_reg.adate[5:0] == state_reg.date[5:0])
        && (state_reg.adow[7] || state_reg.adow[2:0] == state_reg.dow);

    logic step;
    assign step = !access_active && (tick_1hz || state_reg.pending); // see [RULE_06]

    always_comb
    begin
        state_next = state_reg;
        // see [RULE_05]
        if (access_active && tick_1hz)
            state_next.pending = 1'b1; // see [RULE_06]
        if (step)
        begin
            state_next.pending = 1'b0;
            state_next.sec = {state_reg.sec[7], sec_n[6:0]}; // see [RULE_18]
            if (sec_w)
            begin
                state_next.min = min_n;
                if (min_w)
                begin
                    state_next.hr = hr_adv;
                    if (day_carry)
                    begin
                        state_next.dow = (state_reg.dow == RCA_DOW_LAST) ? 3'h0
                                         : state_reg.dow + 3'h1; // see [RULE_02]
                        state_next.date = date_n;
                        if (date_w)
                        begin
                            state_next.month = month_n[4:0]; // see [RULE_03]
                            if (month_w)
                                state_next.year = year_n; // see [RULE_04]
                        end
                    end
                end
            end
        end
        if (wr_en)
        begin
            unique case (addr)
                RCA_OFF_SEC: state_next.sec = wdata;
                RCA_OFF_MIN: state_next.min = wdata & 8'h7F;
                RCA_OFF_HR: state_next.hr = wdata & 8'h3F;
                RCA_OFF_DATE: state_next.date = wdata & 8'h3F;
                RCA_OFF_DOW: state_next.dow = wdata[2:0]; // see [RULE_01]
                RCA_OFF_MONTH: state_next.month = wdata[4:0]; // see [RULE_03]
                RCA_OFF_YEAR: state_next.year = wdata; // see [RULE_04]
                RCA_OFF_AMIN: state_next.amin = wdata & RCA_MASK_AMIN; // see [RULE_10]
                RCA_OFF_AHR: state_next.ahr = wdata & RCA_MASK_AHR; // see [RULE_11]
                RCA_OFF_ADATE: state_next.adate = wdata & RCA_MASK_ADATE; // see [RULE_13]
                RCA_OFF_ADOW: state_next.adow = wdata & RCA_MASK_ADOW; // see [RULE_14]
                default: ;
            endcase
        end
        unique case (addr)
            RCA_OFF_SEC: state_next.rdata = state_reg.sec;
            RCA_OFF_MIN: state_next.rdata = state_reg.min;
            RCA_OFF_HR: state_next.rdata = state_reg.hr;
            RCA_OFF_DATE: state_next.rdata = state_reg.date;
            RCA_OFF_DOW: state_next.rdata = {5'h00, state_reg.dow}; // see [RULE_01]
            RCA_OFF_MONTH: state_next.rdata = {3'h0, state_reg.month};
            RCA_OFF_YEAR: state_next.rdata = state_reg.year;
            RCA_OFF_AMIN: state_next.rdata = state_reg.amin;
            RCA_OFF_AHR: state_next.rdata = state_reg.ahr;
            RCA_OFF_ADATE: state_next.rdata = state_reg.adate;
            RCA_OFF_ADOW: state_next.rdata = state_reg.adow;
            default: state_next.rdata = 8'h00;
        endcase
        // rising edge of the match only, so a lingering match cannot re-arm
        state_next.match_prev = match_now;
        if (alarm_flag_clear)
            state_next.flag = 1'b0;
        if (match_now && !state_reg.match_prev)
            state_next.flag = 1'b1; // see [RULE_16] [RULE_17]
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg <= '{sec: RCA_RST_SEC, min: RCA_RST_MIN, hr: RCA_RST_HR,
                           date: RCA_RST_DATE, dow: RCA_RST_DOW[2:0],
                           month: RCA_RST_MONTH[4:0], year: RCA_RST_YEAR,
                           amin: RCA_RST_ALARM, ahr: RCA_RST_ALARM, adate: RCA_RST_ALARM,
                           adow: RCA_RST_ALARM, pending: 1'b0, match_prev: 1'b0,
                           flag: 1'b0, rdata: 8'h00}; // see [RULE_10] [RULE_15]
        end
        else if (clk_en)
            state_reg <= state_next;
    end

    assign rdata = state_reg.rdata;
    assign alarm_match_flag = state_reg.flag;
    assign sec_out = state_reg.sec;
    assign min_out = state_reg.min;
    assign hr_out = state_reg.hr;
    assign date_out = state_reg.date;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_frozen;
        @(posedge clk) disable iff (!resetn)
        (clk_en && access_active && !wr_en) |=> $stable(state_reg.year)
            && $stable(state_reg.dow) && $stable(state_reg.min);
    endproperty
    a_frozen: assert property (p_frozen) else $error("counter moved during access"); // see [RULE_05]

    property p_pending;
        @(posedge clk) disable iff (!resetn)
        (clk_en && access_active && tick_1hz) |=> state_reg.pending;
    endproperty
    a_pending: assert property (p_pending) else $error("tick not held"); // see [RULE_06]

    property p_release;
        @(posedge clk) disable iff (!resetn)
        (clk_en && state_reg.pending && !access_active && !wr_en) |=> !state_reg.pending
            && state_reg.sec != $past(state_reg.sec);
    endproperty
    a_release: assert property (p_release) else $error("held tick lost"); // see [RULE_06]

    property p_dow_range;
        @(posedge clk) disable iff (!resetn)
        (clk_en && state_reg.dow == 3'h6 && step && sec_w && min_w && day_carry && !wr_en)
            |=> state_reg.dow == 3'h0;
    endproperty
    a_dow_range: assert property (p_dow_range) else $error("weekday no wrap"); // see [RULE_02]

    property p_dow_read;
        @(posedge clk) disable iff (!resetn)
        (clk_en && addr == RCA_OFF_DOW) |=> state_reg.rdata[7:3] == 5'h00;
    endproperty
    a_dow_read: assert property (p_dow_read) else $error("weekday high bits set"); // see [RULE_01]

    property p_flag_set;
        @(posedge clk) disable iff (!resetn)
        (clk_en && match_now && !state_reg.match_prev) |=> alarm_match_flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set"); // see [RULE_16]

    property p_no_reset_flag;
        @(posedge clk) disable iff (!resetn)
        (clk_en && alarm_flag_clear && state_reg.match_prev && match_now) |=> !alarm_match_flag;
    endproperty
    a_no_reset_flag: assert property (p_no_reset_flag) else $error("flag re-set"); // see [RULE_17]

    property p_disabled;
        @(posedge clk) disable iff (!resetn)
        (clk_en && !alarm_match_flag && state_reg.amin[7] && state_reg.ahr[7]
            && state_reg.adate[7] && state_reg.adow[7]) |=> !alarm_match_flag;
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled alarm matched"); // see [RULE_09]

    property p_year_wr;
        @(posedge clk) disable iff (!resetn)
        (clk_en && wr_en && addr == RCA_OFF_YEAR) |=> state_reg.year == $past(wdata);
    endproperty
    a_year_wr: assert property (p_year_wr) else $error("year write lost"); // see [RULE_04]

    c_hold: cover property (@(posedge clk) disable iff (!resetn)
        access_active && tick_1hz ##1 !access_active);
    c_alarm: cover property (@(posedge clk) disable iff (!resetn) $rose(alarm_match_flag));
    c_year: cover property (@(posedge clk) disable iff (!resetn) step && month_w && date_w);
endmodule : rca_calendar_alarm

// ---- rca_pkg.sv ----
/*
 * rca_pkg: register offsets, field positions and reset values for the
 * calendar and alarm register block of the real-time clock.
 * Assumes a byte-wide register port with a 4-bit address from the serial front end.
 */
package rca_pkg;
    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [3:0] RCA_OFF_SEC = 4'h2;
    localparam logic [3:0] RCA_OFF_MIN = 4'h3;
    localparam logic [3:0] RCA_OFF_HR = 4'h4;
    localparam logic [3:0] RCA_OFF_DATE = 4'h5;
    localparam logic [3:0] RCA_OFF_DOW = 4'h6;
    localparam logic [3:0] RCA_OFF_MONTH = 4'h7;
    localparam logic [3:0] RCA_OFF_YEAR = 4'h8;
    localparam logic [3:0] RCA_OFF_AMIN = 4'h9;
    localparam logic [3:0] RCA_OFF_AHR = 4'hA;
    localparam logic [3:0] RCA_OFF_ADATE = 4'hB;
    localparam logic [3:0] RCA_OFF_ADOW = 4'hC;
    // ----------------------------------------------------------------
    // field positions and masks
    // ----------------------------------------------------------------
    localparam int RCA_MATCH_DISABLE_BIT = 7;
    localparam int RCA_AFTERNOON_BIT = 5;
    localparam logic [7:0] RCA_MASK_DOW = 8'h07;
    localparam logic [7:0] RCA_MASK_MONTH = 8'h1F;
    localparam logic [7:0] RCA_MASK_AMIN = 8'hFF;
    localparam logic [7:0] RCA_MASK_AHR = 8'hBF;
    localparam logic [7:0] RCA_MASK_ADATE = 8'hBF;
    localparam logic [7:0] RCA_MASK_ADOW = 8'h87;
    // ----------------------------------------------------------------
    // reset values and weekday wrap point
    // ----------------------------------------------------------------
    localparam logic [7:0] RCA_RST_SEC = 8'h00;
    localparam logic [7:0] RCA_RST_MIN = 8'h00;
    localparam logic [7:0] RCA_RST_HR = 8'h00;
    localparam logic [7:0] RCA_RST_DATE = 8'h01;
    localparam logic [7:0] RCA_RST_DOW = 8'h00;
    localparam logic [7:0] RCA_RST_MONTH = 8'h01;
    localparam logic [7:0] RCA_RST_YEAR = 8'h00;
    localparam logic [7:0] RCA_RST_ALARM = 8'h80;
    localparam logic [2:0] RCA_DOW_LAST = 3'h6;
endpackage : rca_pkg

// ---- rca_bcd_digit.sv ----
/*
 * rca_bcd_digit: one two-digit bcd counter step with a programmable
 * wrap point. Pure combinational; caller holds the state.
 * Assumes inputs are valid bcd; out-of-range values give unpredictable counts.
 */
module rca_bcd_digit
    import rca_pkg::*;
(
    input wire logic [7:0] cur,
    input wire logic [7:0] last,
    input wire logic [7:0] first,
    output logic [7:0] nxt,
    output logic wrap
);
    always_comb
    begin
        wrap = (cur == last);
        if (wrap)
            nxt = first;
        else if (cur[3:0] == 4'h9)
            nxt = {cur[7:4] + 4'h1, 4'h0};
        else
            nxt = {cur[7:4], cur[3:0] + 4'h1};
    end
endmodule : rca_bcd_digit

// ---- rca_host_model.sv ----
/*
 * rca_host_model: host side of the register port; byte accesses framed by access_active.
 * Assumes the block samples access_active, wr_en, addr and wdata on the rising clk edge.
 */
module rca_host_model
(
    input wire logic clk,
    output logic access_active,
    output logic wr_en,
    output logic [3:0] addr,
    output logic [7:0] wdata,
    input wire logic [7:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // access framing
    // ----------------------------------------------------------------
    initial
    begin
        access_active = 1'b0;
        wr_en = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
    end
    task automatic open_acc;
        @(posedge clk);
        access_active <= 1'b1;
    endtask : open_acc
    // closed a few cycles after opening, far inside one second
    task automatic close_acc;
        @(posedge clk);
        access_active <= 1'b0;
        wr_en <= 1'b0;
        wdata <= ~wdata;
    endtask : close_acc
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
    endtask : wr
    // released data line flips so a stale byte is never mistaken for a fresh one
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        wr_en <= 1'b0;
        wdata <= ~wdata;
        addr <= a;
        @(posedge clk);
        @(negedge clk);
        d = rdata;
    endtask : rd
endmodule : rca_host_model

// ---- tb_top.sv ----
/*
 * tb_top: self-checking bench for the calendar and alarm registers.
 * Assumes the block and the host model share one 250 MHz clock.
 */
module tb_top
    import rca_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // plumbing
    // ----------------------------------------------------------------
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic clk_en = 1'b1;
    logic tick_1hz = 1'b0;
    logic hour_mode_12 = 1'b0;
    logic alarm_flag_clear = 1'b0;
    logic access_active;
    logic wr_en;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic alarm_match_flag;
    logic [7:0] sec_out;
    logic [7:0] min_out;
    logic [7:0] hr_out;
    logic [7:0] date_out;
    int failures = 0;
    int n_checks = 0;
    always #2 clk = ~clk;
    rca_calendar_alarm rca_calendar_alarm_inst (.clk(clk), .resetn(resetn), .clk_en(clk_en),
        .tick_1hz(tick_1hz), .access_active(access_active), .wr_en(wr_en), .addr(addr),
        .wdata(wdata), .rdata(rdata), .hour_mode_12(hour_mode_12),
        .alarm_flag_clear(alarm_flag_clear), .alarm_match_flag(alarm_match_flag),
        .sec_out(sec_out), .min_out(min_out), .hr_out(hr_out), .date_out(date_out));
    rca_host_model rca_host_model_inst (.clk(clk), .access_active(access_active),
        .wr_en(wr_en), .addr(addr), .wdata(wdata), .rdata(rdata));
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic results;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rca_host_model_inst.rd(a, d);
        check($sformatf("reg %h", a), d, exp);
    endtask : rd_chk
    // whole group in one access so no rollover splits it
    task automatic burst(input logic [3:0] base, input logic [7:0] v [7], input int n);
        rca_host_model_inst.open_acc();
        for (int i = 0; i < n; i++)
            rca_host_model_inst.wr(4'(base + i), v[i]);
        rca_host_model_inst.close_acc();
        @(negedge clk);
    endtask : burst
    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge clk);
            tick_1hz <= 1'b1;
            @(posedge clk);
            tick_1hz <= 1'b0;
        end
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask : tick
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset_masks;
        logic [7:0] r [7] = '{8'h00, 8'h01, 8'h00, 8'h80, 8'h80, 8'h80, 8'h80};
        logic [7:0] m [8] = '{RCA_MASK_DOW, RCA_MASK_MONTH, 8'hFF, RCA_MASK_AMIN,
            RCA_MASK_AHR, RCA_MASK_ADATE, RCA_MASK_ADOW, 8'h00};
        logic [3:0] a;
        check("date", date_out, 8'h01);
        rca_host_model_inst.open_acc();
        for (int i = 0; i < 7; i++)
            rd_chk(4'(6 + i), r[i]);
        for (int i = 0; i < 8; i++)
        begin
            a = (i == 7) ? 4'hF : 4'(6 + i);
            rca_host_model_inst.wr(a, 8'hFF);
            rd_chk(a, m[i]);
        end
        rca_host_model_inst.close_acc();
    endtask : t_reset_masks
    task automatic t_calendar;
        logic [7:0] c [5][8] = '{'{8'h31, 8'h06, 8'h12, 8'h99, 8'h01, 8'h00, 8'h01, 8'h00},
            '{8'h28, 8'h02, 8'h02, 8'h04, 8'h29, 8'h03, 8'h02, 8'h04},
            '{8'h28, 8'h02, 8'h02, 8'h03, 8'h01, 8'h03, 8'h03, 8'h03},
            '{8'h30, 8'h05, 8'h04, 8'h21, 8'h01, 8'h06, 8'h05, 8'h21},
            '{8'h31, 8'h01, 8'h12, 8'h19, 8'h01, 8'h02, 8'h01, 8'h20}};
        for (int i = 0; i < 5; i++)
        begin
            burst(RCA_OFF_SEC, '{8'h59, 8'h59, 8'h23, c[i][0], c[i][1], c[i][2], c[i][3]}, 7);
            tick(1);
            check("sec", sec_out, 8'h00);
            check("min", min_out, 8'h00);
            check("hr", hr_out, 8'h00);
            check("date", date_out, c[i][4]);
            rca_host_model_inst.open_acc();
            rd_chk(RCA_OFF_DOW, c[i][5]);
            rd_chk(RCA_OFF_MONTH, c[i][6]);
            rd_chk(RCA_OFF_YEAR, c[i][7]);
            rca_host_model_inst.close_acc();
        end
    endtask : t_calendar
    // two ticks land inside one access; only one may survive
    task automatic t_freeze;
        rca_host_model_inst.open_acc();
        tick(2);
        check("sec frozen", sec_out, 8'h00);
        rca_host_model_inst.close_acc();
        repeat (3) @(posedge clk);
        @(negedge clk);
        check("sec after", sec_out, 8'h01);
        // a tick while the clock enable is low must leave no trace
        @(posedge clk);
        clk_en <= 1'b0;
        tick(1);
        check("sec gated", sec_out, 8'h01);
        @(posedge clk);
        clk_en <= 1'b1;
        tick(1);
        check("sec enabled", sec_out, 8'h02);
    endtask : t_freeze
    task automatic clear_flag;
        @(posedge clk);
        alarm_flag_clear <= 1'b1;
        @(posedge clk);
        alarm_flag_clear <= 1'b0;
        @(negedge clk);
        check("flag", {7'h00, alarm_match_flag}, 8'h00);
    endtask : clear_flag
    task automatic t_alarm;
        burst(RCA_OFF_SEC, '{8'h59, 8'h58, 8'h10, 8'h05, 8'h03, 8'h07, 8'h24}, 7);
        burst(RCA_OFF_AMIN, '{8'h59, 8'h10, 8'h87, 8'h85, 8'h00, 8'h00, 8'h00}, 4);
        check("flag", {7'h00, alarm_match_flag}, 8'h00);
        tick(1);
        check("flag", {7'h00, alarm_match_flag}, 8'h01);
        clear_flag();
        tick(1);
        check("flag", {7'h00, alarm_match_flag}, 8'h00);
        @(posedge clk);
        hour_mode_12 <= 1'b1;
        burst(RCA_OFF_SEC, '{8'h59, 8'h59, 8'h31, 8'h05, 8'h03, 8'h07, 8'h24}, 7);
        burst(RCA_OFF_AMIN, '{8'h00, 8'h12, 8'h06, 8'h04, 8'h00, 8'h00, 8'h00}, 4);
        tick(1);
        check("hr", hr_out, 8'h12);
        check("flag", {7'h00, alarm_match_flag}, 8'h01);
    endtask : t_alarm
    // bounded run: a hang counts as a mismatch
    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        results();
    end
    initial
    begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        t_reset_masks();
        t_calendar();
        t_freeze();
        t_alarm();
        results();
    end
endmodule : tb_top
